// >>> logic/acs_pkg.sv
// constants, register map and state type shared by the calibration sequencer
package acs_pkg;
	localparam int DATA_W = 12;
	localparam int CORES = 3;
	localparam int BANKS = 6;
	localparam int ADDR_W = 8;
	localparam int TRIM_W = 8;
	localparam int TMR_W = 16;
	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TRIG = 8'h04;
	localparam logic [7:0] ADDR_DELAY = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_OFFS_A = 8'h10;
	localparam logic [7:0] ADDR_OFFS_B = 8'h14;
	localparam int CTRL_PIN_SEL = 0;
	localparam int CTRL_BG_EN = 1;
	localparam int CTRL_LOW_POWER_ROTATION_ENABLE = 2;
	localparam int CTRL_LP_SW = 3;
	localparam int CTRL_FG_OS = 4;
	localparam int CTRL_BG_OS = 5;
	localparam int CTRL_SINGLE = 6;
	localparam int CTRL_IN_SEL = 7;
	localparam int CTRL_W = 8;
	localparam int TRIG_SOFT_BIT = 0;
	localparam int DLY_SLEEP_LSB = 0;
	localparam int DLY_WAKE_LSB = 8;
	localparam int DLY_FIELD_W = 8;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] DELAY_RST = 16'h1010;
	localparam logic [DATA_W-1:0] MIDCODE = 12'h000;
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_INA = 2'h1;
	localparam logic [1:0] SRC_INB = 2'h2;
	localparam logic [1:0] SRC_CAL = 2'h3;
	localparam logic [1:0] CORE_A_RST = 2'h0;
	localparam logic [1:0] CORE_B_RST = 2'h1;
	localparam logic [1:0] CORE_C_RST = 2'h2;
	////////////////////////////////////////////////////////////////////////
	localparam int CLK_HZ = 20_000_000;
	localparam int DLY_UNIT_US = 1;
	localparam int DLY_UNIT_CYC = DLY_UNIT_US * (CLK_HZ / 1_000_000);
	localparam int OFFSET_CALIBRATION_US = 10;
	localparam int OFFSET_CALIBRATION_CYC = OFFSET_CALIBRATION_US * (CLK_HZ / 1_000_000);
	localparam int STEP_US = 2;
	localparam int STEP_CYC = STEP_US * (CLK_HZ / 1_000_000);
	typedef enum logic [2:0] {
		S_IDLE, S_FG_CAL, S_FG_OS, S_BG_SLEEP, S_BG_WAKE, S_BG_CAL, S_BG_OS, S_BG_SWAP
	} acs_state_e;
endpackage

// >>> logic/acs_delay_timer.sv
// restartable cycle timer: pulses done when the count reaches the target
`timescale 1ns/1ps
module acs_delay_timer #(
	parameter int W = 16
) (
	input wire logic ref_clk_i, // system clock
	input wire logic reset_i, // synchronous reset
	input wire logic run_i, // count while high, clear when low
	input wire logic [W-1:0] target_i, // cycles to wait minus one
	output logic done_o // one-cycle pulse at the target
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	assign done_o = run_i && (cnt_q == target_i);
	// restarting on done lets two timed phases follow back to back
	assign cnt_d = (!run_i || done_o) ? '0 : W'(cnt_q + 1'b1);
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // acs_delay_timer

// >>> logic/acs_bank_cal.sv
// walks both banks of one core through linearity, gain and offset steps
`timescale 1ns/1ps
module acs_bank_cal #(
	parameter int STEP_CYCLES = acs_pkg::STEP_CYC
) (
	input wire logic ref_clk_i, // system clock
	input wire logic reset_i, // synchronous reset
	input wire logic run_i, // calibrate while high
	output logic bank_o, // bank of the core under calibration
	output logic [1:0] param_o, // 0 linearity, 1 gain, 2 offset
	output logic done_o // one-cycle pulse, core finished
);
	localparam int CW = $clog2(STEP_CYCLES + 1);
	logic [CW-1:0] cyc_q;
	logic [1:0] param_q;
	logic bank_q;
	logic step_end;
	assign step_end = run_i && (cyc_q == CW'(STEP_CYCLES - 1));
	assign done_o = step_end && bank_q && (param_q == 2'h2);
	assign bank_o = bank_q;
	assign param_o = param_q;
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !run_i || done_o) begin
			cyc_q <= '0;
			param_q <= 2'h0;
			bank_q <= 1'b0;
		end else if (step_end) begin
			cyc_q <= '0;
			param_q <= (param_q == 2'h2) ? 2'h0 : 2'(param_q + 1'b1);
			bank_q <= (param_q == 2'h2) ? 1'b1 : bank_q;
		end else begin
			cyc_q <= CW'(cyc_q + 1'b1);
		end
	end
endmodule // acs_bank_cal

// >>> logic/acs_cal_sequencer.sv
// calibration sequencer for a three-core interleaved converter, APB slave
// Behaviour
// - foreground calibration takes cores offline and outputs midcode zero
// - background calibration keeps converting, a spare core stands in
// - six banks, two per core, three cores, banks on opposite phases
// - dual channel: core A takes input A, B takes B; single: both same
// - the third core periodically replaces core A and core B
// - spare calibrated first, takes a role; released core calibrated next
// - each calibration covers linearity, gain and offset of every bank
// - foreground calibration runs after power-up; host waits for it
// - trigger source for foreground calibration is pin or software bit
// - low power: offline cores stay powered down until due
// - in automatic low power, sleep delay sets spare sleep time
// - wake delay sets settling time before calibration and going online
// - low-power switch select picks automatic switching or a user-paced hold in which the spare sleeps until background stops
// - foreground offset enable: buffer offset calibrated once in foreground
// - background offset enable: buffer offset corrected repeatedly
// - offset calibration writes trims; host keeps off them meanwhile
// - trims come up with factory values, readable and writable
`timescale 1ns/1ps
module acs_cal_sequencer #(
	parameter int STEP_CYCLES = acs_pkg::STEP_CYC,
	parameter logic [acs_pkg::TRIM_W-1:0] FACTORY_OFFS_A = 8'h80,
	parameter logic [acs_pkg::TRIM_W-1:0] FACTORY_OFFS_B = 8'h80
) (
	input wire logic ref_clk_i, // 20 MHz clock
	input wire logic reset_i, // synchronous, active high
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb enable
	input wire logic pwrite_i, // apb direction
	input wire logic [acs_pkg::ADDR_W-1:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error, unmapped address
	input wire logic calibration_trigger_pin_i, // asynchronous trigger pin
	input wire logic [acs_pkg::CORES*acs_pkg::DATA_W-1:0] core_data_i, // core words
	input wire logic [acs_pkg::TRIM_W-1:0] offset_est_a_i, // offset estimate, input a
	input wire logic [acs_pkg::TRIM_W-1:0] offset_est_b_i, // offset estimate, input b
	output logic [acs_pkg::DATA_W-1:0] chan_a_o, // output samples, channel a
	output logic [acs_pkg::DATA_W-1:0] chan_b_o, // output samples, channel b
	output logic [2*acs_pkg::CORES-1:0] core_src_o, // per-core input source
	output logic [acs_pkg::CORES-1:0] core_power_o, // per-core power enable
	output logic [acs_pkg::BANKS-1:0] bank_sample_o, // per-bank sample strobe
	output logic cal_active_o, // a core is under calibration
	output logic [1:0] cal_core_o, // core under calibration
	output logic cal_bank_o, // bank under calibration
	output logic [1:0] cal_param_o, // parameter under calibration
	output logic offset_cal_active_o, // input buffer offset calibration running
	output logic foreground_complete_flag_o, // foreground calibration done
	output logic [acs_pkg::TRIM_W-1:0] input_offset_trim_value_a_o, // trim a
	output logic [acs_pkg::TRIM_W-1:0] input_offset_trim_value_b_o // trim b
);
	import acs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// registers and state
	acs_state_e state_q, state_d;
	logic [CTRL_W-1:0] ctrl_q;
	logic [15:0] dly_q;
	logic soft_q, soft_prev_q;
	logic [TRIM_W-1:0] offs_a_q, offs_b_q;
	logic pin_s1_q, pin_s2_q, pin_prev_q;
	logic pwrup_q, done_q;
	logic [1:0] role_a_q, role_b_q, spare_q, fg_idx_q;
	logic swap_to_b_q, phase_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic [DATA_W-1:0] chan_a_q, chan_b_q;
	logic [2*CORES-1:0] src_q;
	logic [CORES-1:0] pwr_q;
	logic [BANKS-1:0] bank_q;
	logic cal_act_q, cal_bank_q, os_act_q;
	logic [1:0] cal_core_q, cal_param_q;

	////////////////////////////////////////////////////////////////////////
	// apb decode
	wire setup_acc = psel_i && penable_i && !pready_q;
	wire access = psel_i && penable_i && pready_q;
	wire wr_en = access && pwrite_i;
	wire hit_ctrl = paddr_i == ADDR_CTRL;
	wire hit_trig = paddr_i == ADDR_TRIG;
	wire hit_dly = paddr_i == ADDR_DELAY;
	wire hit_stat = paddr_i == ADDR_STATUS;
	wire hit_oa = paddr_i == ADDR_OFFS_A;
	wire hit_ob = paddr_i == ADDR_OFFS_B;
	wire hit_any = hit_ctrl | hit_trig | hit_dly | hit_stat | hit_oa | hit_ob;
	wire fg_active = (state_q == S_FG_CAL) || (state_q == S_FG_OS);
	wire bg_busy = !fg_active && (state_q != S_IDLE);
	wire os_state = (state_q == S_FG_OS) || (state_q == S_BG_OS);
	wire [31:0] status_w = {23'h0, pwr_q[spare_q], spare_q, role_b_q, role_a_q,
		fg_active, done_q};
	wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_q} :
		hit_trig ? {31'h0, soft_q} :
		hit_dly ? {16'h0, dly_q} :
		hit_stat ? status_w :
		hit_oa ? {24'h0, offs_a_q} :
		hit_ob ? {24'h0, offs_b_q} : 32'h0;

	////////////////////////////////////////////////////////////////////////
	// control bits and triggers
	wire pin_sel = ctrl_q[CTRL_PIN_SEL];
	wire bg_en = ctrl_q[CTRL_BG_EN];
	wire low_power_rotation_enable = ctrl_q[CTRL_LOW_POWER_ROTATION_ENABLE];
	wire lp_user = ctrl_q[CTRL_LP_SW];
	wire fg_os_en = ctrl_q[CTRL_FG_OS];
	wire bg_os_en = ctrl_q[CTRL_BG_OS];
	wire single = ctrl_q[CTRL_SINGLE];
	wire in_sel = ctrl_q[CTRL_IN_SEL];
	// background needs pin select off and the software bit held high
	wire bg_ok = bg_en && !pin_sel && soft_q;
	wire pin_edge = pin_s2_q && !pin_prev_q;
	wire soft_edge = soft_q && !soft_prev_q;
	wire trig_edge = pin_sel ? pin_edge : soft_edge;

	////////////////////////////////////////////////////////////////////////
	// calibration engine and delay timer
	wire cal_run = (state_q == S_FG_CAL) || (state_q == S_BG_CAL);
	wire [1:0] cal_core_w = fg_active ? fg_idx_q : spare_q;
	wire eng_done, eng_bank, tmr_done;
	wire [1:0] eng_param;
	wire tmr_run = ((state_q == S_BG_SLEEP) && !lp_user) || (state_q == S_BG_WAKE)
		|| os_state;
	wire [TMR_W-1:0] sleep_cyc = TMR_W'(dly_q[DLY_SLEEP_LSB +: DLY_FIELD_W]
		* TMR_W'(DLY_UNIT_CYC));
	wire [TMR_W-1:0] wake_cyc = TMR_W'(dly_q[DLY_WAKE_LSB +: DLY_FIELD_W]
		* TMR_W'(DLY_UNIT_CYC));
	wire [TMR_W-1:0] tmr_target = (state_q == S_BG_SLEEP) ? sleep_cyc :
		(state_q == S_BG_WAKE) ? wake_cyc :
		TMR_W'(OFFSET_CALIBRATION_CYC - 1);
	wire os_write = os_state && tmr_done;

	acs_bank_cal #(.STEP_CYCLES(STEP_CYCLES)) u_bank_cal (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.run_i(cal_run),
		.bank_o(eng_bank),
		.param_o(eng_param),
		.done_o(eng_done)
	);

	acs_delay_timer #(.W(TMR_W)) u_timer (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.run_i(tmr_run),
		.target_i(tmr_target),
		.done_o(tmr_done)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: begin
				if (pwrup_q || (trig_edge && !bg_ok)) begin
					state_d = S_FG_CAL;
				end else if (bg_ok) begin
					state_d = low_power_rotation_enable ? S_BG_SLEEP : S_BG_CAL;
				end
			end
			S_FG_CAL: begin
				if (eng_done && fg_idx_q == CORE_C_RST) begin
					state_d = fg_os_en ? S_FG_OS : S_IDLE;
				end
			end
			S_FG_OS: begin
				if (tmr_done) begin
					state_d = S_IDLE;
				end
			end
			S_BG_SLEEP: begin
				if (!bg_ok) begin
					state_d = S_IDLE;
				end else if (lp_user ? trig_edge : tmr_done) begin
					state_d = S_BG_WAKE;
				end
			end
			S_BG_WAKE: begin
				if (tmr_done) begin
					state_d = S_BG_CAL;
				end
			end
			S_BG_CAL: begin
				if (eng_done) begin
					state_d = bg_os_en ? S_BG_OS : S_BG_SWAP;
				end
			end
			S_BG_OS: begin
				if (tmr_done) begin
					state_d = S_BG_SWAP;
				end
			end
			S_BG_SWAP: begin
				state_d = !bg_ok ? S_IDLE : (low_power_rotation_enable ? S_BG_SLEEP : S_BG_CAL);
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_q <= S_IDLE;
			pwrup_q <= 1'b1;
			done_q <= 1'b0;
			fg_idx_q <= CORE_A_RST;
		end else begin
			state_q <= state_d;
			if (state_d == S_FG_CAL && state_q == S_IDLE) begin
				pwrup_q <= 1'b0;
				done_q <= 1'b0;
				fg_idx_q <= CORE_A_RST;
			end else if (state_q == S_FG_CAL && eng_done) begin
				fg_idx_q <= 2'(fg_idx_q + 1'b1);
			end
			if (fg_active && state_d == S_IDLE) begin
				done_q <= 1'b1;
			end
		end
	end

	// the spare core takes the next role in turn, the released core becomes spare
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			role_a_q <= CORE_A_RST;
			role_b_q <= CORE_B_RST;
			spare_q <= CORE_C_RST;
			swap_to_b_q <= 1'b0;
		end else if (state_q == S_BG_SWAP) begin
			swap_to_b_q <= !swap_to_b_q;
			spare_q <= swap_to_b_q ? role_b_q : role_a_q;
			role_a_q <= swap_to_b_q ? role_a_q : spare_q;
			role_b_q <= swap_to_b_q ? spare_q : role_b_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_q <= CTRL_RST;
			dly_q <= DELAY_RST;
			soft_q <= 1'b0;
			soft_prev_q <= 1'b0;
			offs_a_q <= FACTORY_OFFS_A;
			offs_b_q <= FACTORY_OFFS_B;
		end else begin
			soft_prev_q <= soft_q;
			if (wr_en && hit_ctrl) begin
				ctrl_q <= pwdata_i[CTRL_W-1:0];
			end
			if (wr_en && hit_dly) begin
				dly_q <= pwdata_i[15:0];
			end
			if (wr_en && hit_trig) begin
				soft_q <= pwdata_i[TRIG_SOFT_BIT];
			end
			// calibration owns the trims while it writes them
			if (os_write) begin
				offs_a_q <= offset_est_a_i;
				offs_b_q <= offset_est_b_i;
			end else if (wr_en && !os_state) begin
				offs_a_q <= hit_oa ? pwdata_i[TRIM_W-1:0] : offs_a_q;
				offs_b_q <= hit_ob ? pwdata_i[TRIM_W-1:0] : offs_b_q;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= setup_acc;
			pslverr_q <= setup_acc && !hit_any;
			prdata_q <= (setup_acc && !pwrite_i) ? rd_mux : 32'h0;
		end
	end

	// two flops before the pin is looked at
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_s1_q <= calibration_trigger_pin_i;
			pin_s2_q <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core steering, power and bank phases
	logic [DATA_W-1:0] core_word [CORES];
	logic [2*CORES-1:0] src_w;
	logic [CORES-1:0] pwr_w;
	logic [BANKS-1:0] bank_w;
	wire [1:0] single_src = in_sel ? SRC_INB : SRC_INA;
	// a sleeping spare wakes only for its wake, calibration and offset phases
	wire spare_awake = !low_power_rotation_enable || !bg_busy || (state_q == S_BG_WAKE) || cal_run
		|| (state_q == S_BG_OS);

	for (genvar c = 0; c < CORES; c++) begin : g_core
		wire is_a = role_a_q == 2'(c);
		wire is_b = role_b_q == 2'(c);
		wire on_cal = cal_run && (cal_core_w == 2'(c));
		assign core_word[c] = core_data_i[c*DATA_W +: DATA_W];
		assign src_w[2*c +: 2] = on_cal ? SRC_CAL : fg_active ? SRC_NONE :
			is_a ? (single ? single_src : SRC_INA) :
			is_b ? (single ? single_src : SRC_INB) : SRC_NONE;
		assign pwr_w[c] = (spare_q != 2'(c)) || spare_awake;
		assign bank_w[2*c] = pwr_w[c] && phase_q;
		assign bank_w[2*c+1] = pwr_w[c] && !phase_q;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			phase_q <= 1'b0;
			chan_a_q <= MIDCODE;
			chan_b_q <= MIDCODE;
			src_q <= '0;
			pwr_q <= '1;
			bank_q <= '0;
		end else begin
			phase_q <= !phase_q;
			chan_a_q <= fg_active ? MIDCODE : core_word[role_a_q];
			chan_b_q <= fg_active ? MIDCODE : core_word[role_b_q];
			src_q <= src_w;
			pwr_q <= pwr_w;
			bank_q <= bank_w;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cal_act_q <= 1'b0;
			cal_core_q <= 2'h0;
			cal_bank_q <= 1'b0;
			cal_param_q <= 2'h0;
			os_act_q <= 1'b0;
		end else begin
			cal_act_q <= cal_run;
			cal_core_q <= cal_core_w;
			cal_bank_q <= eng_bank;
			cal_param_q <= eng_param;
			os_act_q <= os_state;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign chan_a_o = chan_a_q;
	assign chan_b_o = chan_b_q;
	assign core_src_o = src_q;
	assign core_power_o = pwr_q;
	assign bank_sample_o = bank_q;
	assign cal_active_o = cal_act_q;
	assign cal_core_o = cal_core_q;
	assign cal_bank_o = cal_bank_q;
	assign cal_param_o = cal_param_q;
	assign offset_cal_active_o = os_act_q;
	assign foreground_complete_flag_o = done_q;
	assign input_offset_trim_value_a_o = offs_a_q;
	assign input_offset_trim_value_b_o = offs_b_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	a_midcode_out: assert property (fg_active |=> chan_a_q == MIDCODE
		&& chan_b_q == MIDCODE) else $error("output not midcode in foreground");
	a_bg_passthru: assert property (bg_busy |=>
		chan_a_q == $past(core_word[role_a_q])) else $error("background dropped data");
	a_roles_apart: assert property (role_a_q != role_b_q && spare_q != role_a_q
		&& spare_q != role_b_q) else $error("core roles overlap");
	sequence s_swap;
		state_q == S_BG_SWAP;
	endsequence
	a_swap_roles: assert property (s_swap |=> $past(spare_q) ==
		(($past(swap_to_b_q)) ? role_b_q : role_a_q)) else $error("spare not swapped in");
	a_bank_phase: assert property (bank_q[0] |-> !bank_q[1])
		else $error("banks of a core on same phase");
	a_done_low: assert property (fg_active |-> !done_q)
		else $error("done flag high during foreground");
	a_done_high: assert property ($fell(fg_active) |-> done_q)
		else $error("done flag not set at end");
	a_pin_start: assert property (state_q == S_IDLE && pin_sel && pin_edge && !bg_ok
		|=> fg_active) else $error("trigger did not start calibration");
	a_spare_sleep: assert property (state_q == S_BG_SLEEP && low_power_rotation_enable
		|=> !pwr_q[$past(spare_q)]) else $error("sleeping spare powered");
	a_os_once: assert property (state_q == S_FG_OS ##1 state_q != S_FG_OS
		|-> state_q == S_IDLE) else $error("offset calibration repeated");
endmodule // acs_cal_sequencer

// >>> tb/acs_host_model.sv
// host-side model: trigger pin, core sample words and offset estimates
`timescale 1ns/1ps
module acs_host_model (
	input wire logic ref_clk_i, // system clock
	output logic calibration_trigger_pin_o, // trigger pin to the device
	output logic [acs_pkg::CORES*acs_pkg::DATA_W-1:0] core_data_o, // word per core
	output logic [acs_pkg::TRIM_W-1:0] offset_est_a_o, // offset estimate, input a
	output logic [acs_pkg::TRIM_W-1:0] offset_est_b_o // offset estimate, input b
);
	import acs_pkg::*;
	// distinct nonzero words so midcode or a wrong core shows at the outputs
	assign core_data_o = {12'h333, 12'h222, 12'h111};
	// estimates are constants, so the trims written by offset calibration are known
	assign offset_est_a_o = 8'h5A;
	assign offset_est_b_o = 8'hA5;
	initial begin
		calibration_trigger_pin_o = 1'b0;
	end
	// held high long enough to pass the two-flop synchroniser
	task automatic pulse_pin();
		@(posedge ref_clk_i);
		calibration_trigger_pin_o <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		calibration_trigger_pin_o <= 1'b0;
	endtask
endmodule // acs_host_model

// >>> tb/testbench.sv
// self-checking bench for the calibration sequencer
`timescale 1ns/1ps
module testbench;
	import acs_pkg::*;
	logic ref_clk_i, reset_i, psel, penable, pwrite, pready, pslverr, pin;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [35:0] core_data;
	logic [7:0] est_a, est_b, trim_a, trim_b;
	logic [11:0] chan_a, chan_b;
	logic [5:0] core_src, bank_sample;
	logic [2:0] core_power;
	logic cal_active, cal_bank, os_active, done_flag, os_seen, mid_seen, bg_watch, cal_seen;
	logic [1:0] cal_core, cal_param;
	int miscompares, n_tests;
	////////////////////////////////////////////////////////////////////////
	acs_cal_sequencer #(.STEP_CYCLES(2)) acs_cal_sequencer_i (.ref_clk_i(ref_clk_i),
		.reset_i(reset_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .calibration_trigger_pin_i(pin), .core_data_i(core_data),
		.offset_est_a_i(est_a), .offset_est_b_i(est_b), .chan_a_o(chan_a),
		.chan_b_o(chan_b), .core_src_o(core_src), .core_power_o(core_power),
		.bank_sample_o(bank_sample), .cal_active_o(cal_active), .cal_core_o(cal_core),
		.cal_bank_o(cal_bank), .cal_param_o(cal_param), .offset_cal_active_o(os_active),
		.foreground_complete_flag_o(done_flag), .input_offset_trim_value_a_o(trim_a),
		.input_offset_trim_value_b_o(trim_b));
	acs_host_model acs_host_model_i (.ref_clk_i(ref_clk_i), .calibration_trigger_pin_o(pin),
		.core_data_o(core_data), .offset_est_a_o(est_a), .offset_est_b_o(est_b));
	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	// monitors sample away from the launching edge
	always @(negedge ref_clk_i) begin
		if (os_active === 1'b1) os_seen = 1'b1;
		if (cal_active === 1'b1 && cal_bank === 1'b1 && cal_param === 2'h2) cal_seen = 1'b1;
		if (bg_watch && (chan_a === 12'h000 || chan_b === 12'h000)) mid_seen = 1'b1;
	end
	task automatic report_and_stop();
		if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// bus cycle: setup, access held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		// ready, read data and error are all taken at the one rising edge
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk_i);
			if (pready === 1'b1) break;
		end
		if (n == 50) begin
			chk(0, 1);
			report_and_stop();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
		chk({31'h0, e}, {31'h0, exp_err});
	endtask
	// bounded wait on the completion flag
	task automatic wait_flag(input logic v);
		int n;
		for (n = 0; n < 2000 && done_flag !== v; n++) @(negedge ref_clk_i);
		chk({31'h0, done_flag}, {31'h0, v});
		if (n == 2000) report_and_stop();
	endtask
	// poll status until the masked field matches
	task automatic poll(input logic [31:0] mask, input logic [31:0] v);
		logic [31:0] r;
		logic e;
		int n;
		for (n = 0; n < 300; n++) begin
			apb(1'b0, ADDR_STATUS, 32'h0, r, e);
			if ((r & mask) === v) break;
		end
		chk(r & mask, v);
		if (n == 300) report_and_stop();
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		miscompares = 0;
		n_tests = 0;
		os_seen = 1'b0;
		mid_seen = 1'b0;
		bg_watch = 1'b0;
		cal_seen = 1'b0;
		reset_i = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (12) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		repeat (3) @(negedge ref_clk_i);
		chk(done_flag, 1'b0);
		chk(chan_a, MIDCODE);
		chk(chan_b, MIDCODE);
		wait_flag(1'b1);
		@(negedge ref_clk_i);
		chk(chan_a, 12'h111);
		chk(chan_b, 12'h222);
		chk(core_src[3:0], {SRC_INB, SRC_INA});
		chk(cal_seen, 1'b1);
		chk(bank_sample[0] ^ bank_sample[1], 1'b1);
		rd_chk(ADDR_CTRL, {24'h0, CTRL_RST}, 1'b0);
		rd_chk(ADDR_DELAY, {16'h0, DELAY_RST}, 1'b0);
		rd_chk(ADDR_OFFS_A, 32'h80, 1'b0);
		wr(ADDR_OFFS_B, 32'h3C);
		rd_chk(ADDR_OFFS_B, 32'h3C, 1'b0);
		rd_chk(8'h40, 32'h0, 1'b1);
		// single channel on input b, started by the software bit
		wr(ADDR_CTRL, 32'h1 << CTRL_SINGLE | 32'h1 << CTRL_IN_SEL);
		wr(ADDR_TRIG, 32'h1);
		wait_flag(1'b0);
		@(negedge ref_clk_i);
		chk(chan_a, MIDCODE);
		wait_flag(1'b1);
		// steering is registered from the idle state, one cycle after the flag
		@(negedge ref_clk_i);
		chk(core_src[3:0], {SRC_INB, SRC_INB});
		wr(ADDR_TRIG, 32'h0);
		// pin trigger with one-time offset calibration, enabled beforehand
		wr(ADDR_CTRL, 32'h1 << CTRL_PIN_SEL | 32'h1 << CTRL_FG_OS);
		os_seen = 1'b0;
		acs_host_model_i.pulse_pin();
		wait_flag(1'b0);
		wait_flag(1'b1);
		chk(os_seen, 1'b1);
		rd_chk(ADDR_OFFS_A, 32'h5A, 1'b0);
		rd_chk(ADDR_OFFS_B, 32'hA5, 1'b0);
		chk(trim_a, 8'h5A);
		chk(trim_b, 8'hA5);
		// background rotation with repeated offset correction
		os_seen = 1'b0;
		bg_watch = 1'b1;
		wr(ADDR_CTRL, 32'h1 << CTRL_BG_EN | 32'h1 << CTRL_BG_OS);
		wr(ADDR_TRIG, 32'h1);
		// first swap hands role a to the spare, second hands role b to the released core
		poll(32'hFC, {24'h0, CORE_A_RST, CORE_B_RST, CORE_C_RST, 2'h0});
		poll(32'hFC, {24'h0, CORE_B_RST, CORE_A_RST, CORE_C_RST, 2'h0});
		chk(mid_seen, 1'b0);
		chk(os_seen, 1'b1);
		// low-power rotation, dual channel only
		wr(ADDR_CTRL, 32'h1 << CTRL_BG_EN | 32'h1 << CTRL_LOW_POWER_ROTATION_ENABLE);
		poll(32'h100, 32'h0);
		@(negedge ref_clk_i);
		chk($countones(core_power), 2);
		// the spare wakes after its sleep delay and settles before calibration
		poll(32'h100, 32'h100);
		@(negedge ref_clk_i);
		chk($countones(core_power), 3);
		chk(mid_seen, 1'b0);
		report_and_stop();
	end
endmodule // testbench
